/* hdl/ocfl_pkg.sv */
// constants, types and register map of the over-current fault logic
// assumes a single clk_sys domain at 250 MHz and an active-high reset
package ocfl_pkg;

  localparam int CLK_MHZ = 250;

  // total-limit filter: a slow excursion must last this long
  localparam int SLOW_FILT_US = 50;
  localparam int SLOW_FILT_CYC = SLOW_FILT_US * CLK_MHZ;
  // one millisecond of clk_sys, unit of the per-phase latch-off delay
  localparam int MS_CYC = 1000 * CLK_MHZ;
  // settle time of the strap pin after the source current is applied
  localparam int STRAP_SETTLE_US = 10;
  localparam logic [11:0] STRAP_SETTLE_CYC = 12'(STRAP_SETTLE_US * CLK_MHZ);

  // analog figures, kept for reference by software and sense front end
  localparam int SLOW_SINK_UA = 10;
  localparam int FAST_SINK_UA = 15;
  localparam int STRAP_SOURCE_UA = 10;
  localparam int IMON_FULL_SCALE_MV = 2000;

  // per-phase threshold in mV and latch-off delay in ms by strap code field
  localparam logic [7:0] PHASE_THR_MV [4] = '{8'h41, 8'h4b, 8'h64, 8'h86};
  localparam logic [3:0] PHASE_DLY_MS [4] = '{4'h4, 4'h6, 4'h8, 4'ha};

  // register offsets
  localparam logic [7:0] REG_CFG    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_CLEAR  = 8'h02;
  localparam logic [7:0] REG_IRQ_EN = 8'h03;
  localparam logic [7:0] REG_STATE  = 8'h04;
  localparam logic [7:0] REG_IMON   = 8'h05;

  // status bit positions
  localparam int ST_SLOW  = 0;
  localparam int ST_FAST  = 1;
  localparam int ST_PHASE = 2;
  localparam int ST_LATCH = 3;
  localparam int ST_STRAP = 4;
  localparam int ST_W     = 5;

  localparam logic [ST_W-1:0] IRQ_EN_RST = 5'h00;

  typedef struct packed {
    logic [1:0] dly_sel;
    logic [1:0] thr_sel;
    logic       override;
  } ocfl_cfg_s;

  localparam ocfl_cfg_s CFG_RST = '{dly_sel: 2'h0, thr_sel: 2'h0,
                                    override: 1'b0};

  typedef enum logic [1:0] {
    FSM_OFF     = 2'b00,
    FSM_STRAP   = 2'b01,
    FSM_RUN     = 2'b10,
    FSM_LATCHED = 2'b11
  } ocfl_state_e;

endpackage : ocfl_pkg

/* hdl/ocfl_sync.sv */
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to clk_sys
module ocfl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : ocfl_sync

/* hdl/ocfl_hold_timer.sv */
// counts how long a level has stood without a break
// assumes level is synchronous to clk_sys
module ocfl_hold_timer (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        level,
  input  wire logic [23:0] limit,
  output logic             expired
);

  logic [23:0] cnt;

  // any drop of the level restarts the count
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt <= '0;
    else if (!level)
      cnt <= '0;
    else if (cnt != limit)
      cnt <= cnt + 24'h000001;
  end

  assign expired = level && (cnt == limit);

endmodule : ocfl_hold_timer

/* hdl/ocfl_top.sv */
// over-current fault decision, strap sampling, limit scaling and registers
// assumes analog comparators and supply monitors drive asynchronous levels;
// phase mask, phase count and converter readings come from clk_sys logic
import ocfl_pkg::*;

// Functional notes
// (RQ1) slow total fault only after limit comparator holds fifty microseconds
// (RQ2) fast total fault trips at once, with no filter time
// (RQ3) any over-current fault shuts converter down and latches it off
// (RQ4) each active phase compared; trips same latch after selected delay
// (RQ5) at startup source strap current and sample the strap code once
// (RQ6) strap code picks threshold group member and latch-off delay group
// (RQ7) host may override strapped threshold and delay after startup
// (RQ8) power-save low scales total limit by active over configured phases
// (RQ9) stay inactive until main and ramp supplies both clear lockout
// (RQ10) digitised current-monitor reading kept; full scale means max load
// (RQ11) latch clears only on enable toggle or supply lockout
module ocfl_top #(
  parameter int SLOW_FILT_CYC_P = ocfl_pkg::SLOW_FILT_CYC,
  parameter int MS_CYC_P        = ocfl_pkg::MS_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // analog and pin levels
  input  wire logic        total_limit_slow_trip,
  input  wire logic        total_limit_fast_trip,
  input  wire logic [7:0]  per_phase_limit_trip,
  input  wire logic        main_supply_ok,
  input  wire logic        ramp_supply_ok,
  input  wire logic        enable_pin,
  input  wire logic        power_save_select,
  input  wire logic [3:0]  strap_code,
  // same-clock inputs
  input  wire logic [7:0]  active_phase_mask,
  input  wire logic [3:0]  configured_phases,
  input  wire logic [9:0]  imon_code,
  input  wire logic        imon_valid,
  // outputs
  output logic             strap_source_en,
  output logic [1:0]       phase_threshold_sel,
  output logic [3:0]       limit_scale_num,
  output logic [3:0]       limit_scale_den,
  output logic             converter_active,
  output logic             overcurrent_guard,
  output logic             irq
);

  import ocfl_pkg::*;

  function automatic logic [3:0] count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
      n = n + {3'h0, v[i]};
    return n;
  endfunction : count_ones

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  // synchronised pin levels
  logic [13:0] pins_raw;
  logic [13:0] pins_s;
  logic        slow_s;
  logic        fast_s;
  logic [7:0]  phase_s;
  logic        main_ok_s;
  logic        ramp_ok_s;
  logic        enable_s;
  logic        psave_s;

  assign pins_raw = {total_limit_slow_trip, total_limit_fast_trip,
                     per_phase_limit_trip, main_supply_ok, ramp_supply_ok,
                     enable_pin, power_save_select};

  ocfl_sync #(
    .W (14)
  ) u_sync_pins (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (pins_raw),
    .q       (pins_s)
  );

  assign {slow_s, fast_s, phase_s, main_ok_s, ramp_ok_s, enable_s,
          psave_s} = pins_s;

  // strap code is read only while the strap source is on
  logic [3:0] strap_s;

  ocfl_sync #(
    .W (4)
  ) u_sync_strap (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (strap_code),
    .q       (strap_s)
  );

  // state
  ocfl_state_e     state;
  ocfl_state_e     next_state;
  ocfl_cfg_s       cfg;
  logic [3:0]      strap_val;
  logic            strap_done;
  logic [11:0]     settle_cnt;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] irq_en;
  logic [9:0]      imon;

  logic supplies_ok;
  logic in_run;
  logic slow_fault;
  logic fast_fault;
  logic phase_fault;
  logic any_fault;
  logic settle_done;

  assign supplies_ok = main_ok_s && ramp_ok_s; // RQ9
  assign in_run      = (state == FSM_RUN);
  assign settle_done = (settle_cnt == STRAP_SETTLE_CYC);

  // effective per-phase setting: host value replaces strapped one
  logic [1:0] eff_thr;
  logic [1:0] eff_dly;
  assign eff_thr = cfg.override ? cfg.thr_sel : strap_val[1:0]; // RQ7
  assign eff_dly = cfg.override ? cfg.dly_sel : strap_val[3:2]; // RQ6

  // latch-off delay in cycles from the selected millisecond figure
  logic [23:0] phase_limit;
  assign phase_limit = 24'(PHASE_DLY_MS[eff_dly] * MS_CYC_P); // RQ6

  // slow total-current filter
  ocfl_hold_timer u_slow_filt (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (slow_s && in_run),
    .limit   (24'(SLOW_FILT_CYC_P)),
    .expired (slow_fault)
  ); // RQ1

  assign fast_fault = fast_s && in_run; // RQ2

  // any active phase over its limit keeps the delay count running
  logic phase_over;
  assign phase_over = |(phase_s & active_phase_mask) && in_run; // RQ4

  ocfl_hold_timer u_phase_filt (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (phase_over),
    .limit   (phase_limit),
    .expired (phase_fault)
  ); // RQ4

  assign any_fault = slow_fault || fast_fault || phase_fault; // RQ3

  always_comb
  begin
    next_state = state;
    case (state)
      FSM_OFF:
        if (supplies_ok && !strap_done)
          next_state = FSM_STRAP; // RQ5
        else if (supplies_ok && enable_s)
          next_state = FSM_RUN; // RQ9
      FSM_STRAP:
        if (!supplies_ok)
          next_state = FSM_OFF;
        else if (settle_done)
          next_state = FSM_OFF;
      FSM_RUN:
        if (!supplies_ok || !enable_s)
          next_state = FSM_OFF;
        else if (any_fault)
          next_state = FSM_LATCHED; // RQ3
      FSM_LATCHED:
        if (!supplies_ok || !enable_s)
          next_state = FSM_OFF; // RQ11
      default:
        next_state = FSM_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state <= FSM_OFF;
    else
      state <= next_state;
  end

  // strap sampling, repeated only after a supply lockout
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      settle_cnt <= '0;
      strap_val  <= '0;
      strap_done <= 1'b0;
    end
    else if (!supplies_ok)
    begin
      settle_cnt <= '0;
      strap_done <= 1'b0;
    end
    else if (state == FSM_STRAP)
    begin
      settle_cnt <= settle_cnt + 12'h001;
      if (settle_done)
      begin
        strap_val  <= strap_s; // RQ5
        strap_done <= 1'b1;
      end
    end
  end

  // register decode
  logic wr_cfg;
  logic wr_clear;
  logic wr_irq_en;
  assign wr_cfg    = reg_wr && hit(reg_addr, REG_CFG);
  assign wr_clear  = reg_wr && hit(reg_addr, REG_CLEAR);
  assign wr_irq_en = reg_wr && hit(reg_addr, REG_IRQ_EN);

  logic [ST_W-1:0] events;
  assign events[ST_SLOW]  = slow_fault && in_run;
  assign events[ST_FAST]  = fast_fault;
  assign events[ST_PHASE] = phase_fault && in_run;
  assign events[ST_LATCH] = in_run && any_fault;
  assign events[ST_STRAP] = (state == FSM_STRAP) && settle_done;

  logic [ST_W-1:0] clr_mask;
  assign clr_mask = wr_clear ? reg_wdata[ST_W-1:0] : '0;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg    <= CFG_RST;
      irq_en <= IRQ_EN_RST;
      status <= '0;
    end
    else
    begin
      if (wr_cfg)
        cfg <= reg_wdata[4:0]; // RQ7
      if (wr_irq_en)
        irq_en <= reg_wdata[ST_W-1:0];
      // a new event wins over a clear in the same cycle
      status <= (status & ~clr_mask) | events;
    end
  end

  // current-monitor reading, full scale stands for maximum load
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      imon <= '0;
    else if (imon_valid)
      imon <= imon_code; // RQ10
  end

  logic [15:0] state_word;
  assign state_word = {PHASE_THR_MV[eff_thr], strap_val, eff_dly,
                       state};

  logic [15:0] next_rdata;
  assign next_rdata =
    !reg_rd                        ? 16'h0000 :
    hit(reg_addr, REG_CFG)    ? {11'h000, cfg} :
    hit(reg_addr, REG_STATUS) ? {11'h000, status} :
    hit(reg_addr, REG_IRQ_EN) ? {11'h000, irq_en} :
    hit(reg_addr, REG_STATE)  ? state_word :
    hit(reg_addr, REG_IMON)   ? {6'h00, imon} :
                                16'h0000;

  // total-limit scaling by phase count in power-save low
  logic [3:0] act_cnt;
  logic [3:0] next_num;
  assign act_cnt  = count_ones(active_phase_mask);
  assign next_num = psave_s ? configured_phases : act_cnt; // RQ8

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata           <= '0;
      strap_source_en     <= 1'b0;
      phase_threshold_sel <= '0;
      limit_scale_num     <= '0;
      limit_scale_den     <= '0;
      converter_active    <= 1'b0;
      overcurrent_guard   <= 1'b0;
      irq                 <= 1'b0;
    end
    else
    begin
      reg_rdata           <= next_rdata;
      strap_source_en     <= (next_state == FSM_STRAP); // RQ5
      phase_threshold_sel <= eff_thr; // RQ4
      limit_scale_num     <= next_num; // RQ8
      limit_scale_den     <= configured_phases; // RQ8
      converter_active    <= (next_state == FSM_RUN); // RQ9
      overcurrent_guard   <= (next_state == FSM_LATCHED); // RQ3
      irq                 <= |(status & irq_en);
    end
  end

endmodule : ocfl_top

/* dv/ocfl_chk_properties.sv */
// timing checks of trips, latch, supply gating and register port
// assumes binding to ocfl_top, sharing its count parameters
module ocfl_chk #(
  parameter int SLOW_FILT_CYC_P = 20,
  parameter int MS_CYC_P        = 10
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        total_limit_slow_trip,
  input wire logic        total_limit_fast_trip,
  input wire logic [7:0]  active_phase_mask,
  input wire logic [3:0]  configured_phases,
  input wire logic        main_supply_ok,
  input wire logic        ramp_supply_ok,
  input wire logic        enable_pin,
  input wire logic        power_save_select,
  input wire logic        strap_source_en,
  input wire logic [3:0]  limit_scale_num,
  input wire logic [3:0]  limit_scale_den,
  input wire logic        converter_active,
  input wire logic        overcurrent_guard
);
  timeunit 1ns;
  timeprecision 1ps;
  import ocfl_pkg::*;
  logic [15:0] slow_run;
  logic [11:0] strap_len;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      slow_run <= 16'h0000;
    else
      slow_run <= (total_limit_slow_trip && converter_active) ?
                  slow_run + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      strap_len <= 12'h000;
    else
      strap_len <= strap_source_en ? strap_len + 12'h001 : 12'h000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_latch_stops_conv: assert property (
    overcurrent_guard |-> !converter_active)
    else $error("active while latched");
  a_slow_trip_bound: assert property (
    slow_run <= 16'(SLOW_FILT_CYC_P + 6)) else $error("slow trip late");
  a_fast_trip_time: assert property (
    total_limit_fast_trip && converter_active && enable_pin
    |-> ##[1:6] overcurrent_guard) else $error("fast trip late");
  a_supply_gate: assert property (
    (!main_supply_ok || !ramp_supply_ok)[*5]
    |-> !converter_active && !strap_source_en)
    else $error("active unsupplied");
  a_enable_clears: assert property (
    !enable_pin[*5] |-> !overcurrent_guard && !converter_active)
    else $error("latch kept with enable low");
  a_latch_holds: assert property (
    (enable_pin && main_supply_ok && ramp_supply_ok)[*4] ##0 overcurrent_guard
    |=> overcurrent_guard) else $error("latch released");
  a_strap_length: assert property (
    $fell(strap_source_en) |-> strap_len == STRAP_SETTLE_CYC + 12'h001)
    else $error("strap window length");
  a_scale_den: assert property (
    !$past(rst) |-> limit_scale_den == $past(configured_phases))
    else $error("scale denominator");
  a_scale_psave: assert property (
    (!power_save_select && $stable(active_phase_mask))[*5]
    |-> limit_scale_num == 4'($countones(active_phase_mask)))
    else $error("scaled numerator");
  a_scale_full: assert property (
    (power_save_select && $stable(configured_phases))[*5]
    |-> limit_scale_num == configured_phases) else $error("full numerator");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
endmodule : ocfl_chk

bind ocfl_top ocfl_chk #(.SLOW_FILT_CYC_P(SLOW_FILT_CYC_P),
  .MS_CYC_P(MS_CYC_P)) i_chk (.clk_sys, .rst, .reg_rd, .reg_rdata,
  .total_limit_slow_trip, .total_limit_fast_trip, .active_phase_mask,
  .configured_phases, .main_supply_ok, .ramp_supply_ok, .enable_pin,
  .power_save_select, .strap_source_en, .limit_scale_num,
  .limit_scale_den, .converter_active, .overcurrent_guard);

/* dv/ocfl_analog_model.sv */
// comparators and strap pin on the far side of the fault logic
// assumes the bench sets sink current and per-phase overs
module ocfl_analog_model (
  input  wire logic       clk_sys,
  input  wire logic       lag,
  input  wire logic [7:0] sink_ua,
  input  wire logic [7:0] phase_over,
  input  wire logic [3:0] strap_sel,
  input  wire logic       strap_source_en,
  output logic            total_limit_slow_trip,
  output logic            total_limit_fast_trip,
  output logic      [7:0] per_phase_limit_trip,
  output logic      [3:0] strap_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       slow_q;
  logic       fast_q;
  logic [7:0] ph_q;
  always_ff @(posedge clk_sys)
  begin
    slow_q <= sink_ua > 8'h0a;
    fast_q <= sink_ua > 8'h0f;
    ph_q   <= phase_over;
    // unsourced pin reads a changing pattern
    strap_code <= strap_source_en ? strap_sel : ~strap_code;
  end
  // lag gives a slow comparator answer
  assign total_limit_slow_trip = lag ? slow_q : sink_ua > 8'h0a;
  assign total_limit_fast_trip = lag ? fast_q : sink_ua > 8'h0f;
  assign per_phase_limit_trip  = lag ? ph_q : phase_over;
endmodule : ocfl_analog_model

/* dv/tb_top.sv */
// self-checking bench of the over-current fault logic
// assumes the comparator model and the bound checker
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ocfl_pkg::*;
  localparam int SLOW = 20;
  logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, sink_ua = 8'h00, phase_over = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        main_supply_ok = 1'b1, ramp_supply_ok = 1'b1, lag = 1'b0;
  logic        enable_pin = 1'b0, power_save_select = 1'b1;
  logic [7:0]  active_phase_mask = 8'hff, per_phase_limit_trip;
  logic [3:0]  configured_phases = 4'h8, strap_sel = 4'h6, strap_code;
  logic [9:0]  imon_code = 10'h000;
  logic        imon_valid = 1'b0, rd_q = 1'b0, irq;
  logic        total_limit_slow_trip, total_limit_fast_trip;
  logic        strap_source_en, converter_active, overcurrent_guard;
  logic [3:0]  limit_scale_num, limit_scale_den;
  logic [1:0]  phase_threshold_sel;
  logic [15:0] expq [$];
  logic [31:0] r;
  int          n_errors = 0, checked = 0, cyc = 0, seed = 58;

  ocfl_top #(.SLOW_FILT_CYC_P(SLOW), .MS_CYC_P(10)) i_dut (.clk_sys, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .total_limit_slow_trip, .total_limit_fast_trip, .per_phase_limit_trip,
    .main_supply_ok, .ramp_supply_ok, .enable_pin, .power_save_select,
    .strap_code, .active_phase_mask, .configured_phases, .imon_code,
    .imon_valid, .strap_source_en, .phase_threshold_sel, .limit_scale_num,
    .limit_scale_den, .converter_active, .overcurrent_guard, .irq);
  ocfl_analog_model i_far (.clk_sys, .lag, .sink_ua, .phase_over,
    .strap_sel, .strap_source_en, .total_limit_slow_trip,
    .total_limit_fast_trip, .per_phase_limit_trip, .strap_code);

  always #2 clk_sys = ~clk_sys;

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic chk(string what, logic [15:0] e, logic [15:0] got);
    checked++;
    if (got !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [15:0] e);
    expq.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    tick(1);
  endtask : rd

  task automatic reen();
    enable_pin <= 1'b0;
    tick(6);
    chk("guard", 0, overcurrent_guard);
    enable_pin <= 1'b1;
    tick(8);
    chk("active", 1, converter_active);
    chk("strap_src", 0, strap_source_en);
  endtask : reen

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge clk_sys)
  begin
    rd_q <= reg_rd;
    cyc  <= cyc + 1;
    if (rd_q)
      chk("reg_rdata", expq.pop_front(), reg_rdata);
    if (cyc == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  initial
  begin
    tick(12);
    rst <= 1'b0;
    tick(100);
    chk("strap_src", 1, strap_source_en);
    tick(2500);
    chk("strap_src", 0, strap_source_en);
    chk("thr_sel", 2, phase_threshold_sel);
    rd(REG_STATE, {8'h64, 4'h6, 2'h1, 2'h0});
    rd(REG_STATUS, 16'h0010);
    wr(REG_CLEAR, 16'h001f);
    wr(REG_IRQ_EN, 16'h0001);
    rd(REG_IRQ_EN, 16'h0001);
    reen();
    sink_ua <= 8'h0c;
    tick(SLOW - 3);
    sink_ua <= 8'h00;
    tick(10);
    chk("guard", 0, overcurrent_guard);
    lag <= 1'b1;
    sink_ua <= 8'h0b;
    tick(SLOW + 8);
    chk("guard", 1, overcurrent_guard);
    chk("active", 0, converter_active);
    sink_ua <= 8'h00;
    tick(20);
    chk("guard", 1, overcurrent_guard);
    chk("irq", 1, irq);
    rd(REG_STATUS, 16'h0009);
    wr(REG_CLEAR, 16'h001f);
    tick(3);
    chk("irq", 0, irq);
    reen();
    sink_ua <= 8'h10;
    tick(2);
    sink_ua <= 8'h00;
    tick(8);
    chk("guard", 1, overcurrent_guard);
    chk("irq", 0, irq);
    rd(REG_STATUS, 16'h000a);
    wr(REG_CLEAR, 16'h001f);
    reen();
    active_phase_mask <= 8'h0f;
    phase_over <= 8'hf0;
    tick(100);
    chk("guard", 0, overcurrent_guard);
    phase_over <= 8'h01;
    tick(55);
    chk("guard", 0, overcurrent_guard);
    tick(15);
    chk("guard", 1, overcurrent_guard);
    phase_over <= 8'h00;
    reen();
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_CFG, {11'h000, 2'(i), 2'(3 - i), 1'b1});
      tick(2);
      chk("thr_sel", 16'(3 - i), phase_threshold_sel);
      rd(REG_STATE, {PHASE_THR_MV[3 - i], 4'h6, 2'(i), 2'h2});
    end
    phase_over <= 8'h01;
    tick(95);
    chk("guard", 0, overcurrent_guard);
    tick(15);
    chk("guard", 1, overcurrent_guard);
    phase_over <= 8'h00;
    power_save_select <= 1'b0;
    repeat (4)
    begin
      r = $random(seed);
      active_phase_mask <= r[7:0];
      tick(8);
      chk("scale_num", 16'($countones(r[7:0])), limit_scale_num);
      chk("scale_den", 16'h0008, limit_scale_den);
    end
    r = $random(seed);
    imon_code  <= r[9:0];
    imon_valid <= 1'b1;
    tick(1);
    imon_valid <= 1'b0;
    rd(REG_IMON, {6'h00, r[9:0]});
    rd(8'h0a, 16'h0000);
    main_supply_ok <= 1'b0;
    tick(6);
    chk("active", 0, converter_active);
    chk("guard", 0, overcurrent_guard);
    main_supply_ok <= 1'b1;
    ramp_supply_ok <= 1'b0;
    tick(6);
    chk("active", 0, converter_active);
    chk("strap_src", 0, strap_source_en);
    ramp_supply_ok <= 1'b1;
    tick(20);
    chk("strap_src", 1, strap_source_en);
    summarize();
  end
endmodule : tb_top
